/* File: pkg/stq_pkg.sv */
// Constants, modes and configuration carrier of the scope trigger qualifier.
// Assumes a single 250 MHz sampling clock; all times become cycle counts here.
package stq_pkg;

    // ------------------------------------------------------------------
    // Channels and widths
    // ------------------------------------------------------------------
    localparam int NCH      = 4;
    localparam int LIM_W    = 26;   // Duration limits, up to 40,000,000 cycles
    localparam int HO_W     = 27;   // Holdoff time, up to 80,000,000 cycles
    localparam int CNT_W    = 24;   // Event and edge counts, up to 16,000,000
    localparam int TS_W     = 40;   // Free running timestamp
    localparam int IDX_W    = 10;   // Record index
    localparam int REC_LEN_DEF = 1024;

    // ------------------------------------------------------------------
    // Clock and times
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int CLK_PERIOD_PS = 4000;
    localparam int TQ_MIN_NS     = 20;
    localparam int TQ_MAX_NS     = 160_000_000;
    localparam int HO_MIN_NS     = 40;
    localparam int HO_MAX_NS     = 320_000_000;
    localparam int DLY_HO_NS     = 40;
    localparam int GLITCH_MIN_PS = 1500;
    localparam int RECOVER_MAX_NS = 12;

    // Least times round up, longest round down
    localparam int TQ_MIN_CYC     = (TQ_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TQ_MAX_CYC     = TQ_MAX_NS / CLK_PERIOD_NS;
    localparam int HO_MIN_CYC     = (HO_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HO_MAX_CYC     = HO_MAX_NS / CLK_PERIOD_NS;
    localparam int DLY_HO_CYC     = (DLY_HO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GLITCH_MIN_CYC = (GLITCH_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int RECOVER_MAX_CYC = (RECOVER_MAX_NS / CLK_PERIOD_NS < 1) ? 1 : RECOVER_MAX_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // Counts
    // ------------------------------------------------------------------
    localparam int EVT_MIN = 2;
    localparam int EVT_MAX = 16_000_000;
    localparam int DLY_MIN = 1;
    localparam int DLY_MAX = 16_000_000;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [TS_W-1:0]  TS_RST  = 40'h00_0000_0000;
    localparam logic [LIM_W-1:0] DUR_RST = 26'h000_0000;
    localparam logic [HO_W-1:0]  HO_RST  = 27'h000_0000;
    localparam logic [CNT_W-1:0] CNT_RST = 24'h00_0000;

    // ------------------------------------------------------------------
    // Enumerations
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_EDGE    = 3'b000,
        MODE_PATTERN = 3'b001,
        MODE_TIMEQ   = 3'b010,
        MODE_STATE   = 3'b011,
        MODE_DELAYED = 3'b100
    } stq_mode_t;

    typedef enum logic [1:0] {
        QUAL_EDGE    = 2'b00,
        QUAL_PATTERN = 2'b01,
        QUAL_TIMEQ   = 2'b10,
        QUAL_STATE   = 2'b11
    } stq_qual_t;

    typedef enum logic [1:0] {
        TQ_SHORTER = 2'b00,
        TQ_LONGER  = 2'b01,
        TQ_RANGE   = 2'b10
    } stq_tq_t;

    typedef enum logic [1:0] {
        REF_LEFT   = 2'b00,
        REF_CENTRE = 2'b01,
        REF_RIGHT  = 2'b10
    } stq_ref_t;

    typedef enum logic [1:0] {
        DS_ARM   = 2'b00,
        DS_COUNT = 2'b01,
        DS_FIRE  = 2'b10
    } stq_dstate_t;

    // ------------------------------------------------------------------
    // Configuration carrier
    // ------------------------------------------------------------------
    typedef struct packed {
        stq_mode_t         mode;
        logic [1:0]        edge_src;
        logic              edge_fall;
        logic [NCH-1:0]    pat_want;     // Wanted level per input
        logic [NCH-1:0]    pat_care;     // Zero means ignored
        logic              pat_exit;     // Fire on exit instead of entry
        stq_tq_t           tq_sel;
        logic [LIM_W-1:0]  tq_lim1;      // Cycles
        logic [LIM_W-1:0]  tq_lim2;      // Cycles
        logic [1:0]        st_clk_src;
        logic              st_clk_fall;
        logic              st_on_false;
        stq_qual_t         arm_sel;
        logic [1:0]        dly_src;
        logic              dly_fall;
        logic [CNT_W-1:0]  dly_count;
        logic [1:0]        trg_src;
        logic              trg_fall;
        logic              ho_by_events;
        logic [HO_W-1:0]   ho_time;      // Cycles
        logic [CNT_W-1:0]  ho_events;
        stq_ref_t          ref_loc;
        logic [31:0]       ref_delay;    // Signed cycles
    } stq_cfg_t;

endpackage : stq_pkg

/* File: design/stq_sync.sv */
// Two flop synchroniser with edge detection for the comparator inputs.
// Assumes asynchronous inputs; edges appear in the same cycle as the level change.
`timescale 1ns/10ps
module stq_sync #(
    parameter int W = 4
) (
    input  wire logic         i_sys_clk,
    input  wire logic         i_rst,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_level,
    output logic      [W-1:0] o_rise,
    output logic      [W-1:0] o_fall
);

    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;
    logic [W-1:0] prev_r;

    // Synchroniser chain; only sync_r reads meta_r
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            meta_r <= '0;
            sync_r <= '0;
            prev_r <= '0;
        end else begin
            meta_r <= i_async;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    // Level and edges from the settled copies
    assign o_level = sync_r;
    assign o_rise  = sync_r & ~prev_r;
    assign o_fall  = ~sync_r & prev_r;

endmodule : stq_sync

/* File: design/stq_top.sv */
// Trigger qualifier: edge, pattern, time-qualified, state and event-delayed modes,
// holdoff and reference point placement.
// Assumes comparator outputs arrive asynchronously and settings are held steady
// by the control logic on i_sys_clk.
//
// Function
// - Edge mode fires on chosen edge of one input.
// - Pattern: high, low or ignored per input.
// - Pattern fires on entry or on exit.
// - Timed pattern fires on exit if shorter, longer or in range.
// - Duration limits programmable from 20 ns to 160 ms.
// - Duration filter rearms within 12 ns.
// - Shorter-than needs the pattern present for at least one cycle.
// - Glitch capture down to 1.5 ns via shorter-than.
// - State: chosen input clocks three-input pattern of the others, true or false.
// - Delayed mode first arms on a chosen qualifier.
// - Armed: count delay edges, fire on next chosen edge.
// - Delay counter keeps up with 70 MHz edges.
// - Reference equals trigger time plus delay; left, centre or right.
// - Holdoff after trigger by time 40 ns-320 ms or 2-16M events; fixed 40 ns time in delayed mode.
`timescale 1ns/10ps
module stq_top
    import stq_pkg::*;
#(
    parameter int REC_LEN     = REC_LEN_DEF,
    parameter int LIM_MAX_CYC = TQ_MAX_CYC,
    parameter int HOT_MAX_CYC = HO_MAX_CYC,
    parameter int EVT_MAX_CNT = EVT_MAX,
    parameter int DLY_MAX_CNT = DLY_MAX
) (
    input  wire logic             i_sys_clk,
    input  wire logic             i_rst,
    input  wire logic [NCH-1:0]   i_comp,
    input  wire stq_cfg_t         i_cfg,
    output logic                  o_trig,
    output logic [TS_W-1:0]       o_trig_time,
    output logic [TS_W-1:0]       o_ref_time,
    output logic [IDX_W-1:0]      o_ref_idx,
    output logic                  o_holdoff,
    output logic [1:0]            o_dly_state,
    output logic                  o_pat_true
);

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------

    // Selected edge of one input
    function automatic logic edge_of(input logic [1:0] src, input logic fall,
                                     input logic [NCH-1:0] rise_v, input logic [NCH-1:0] fall_v);
        edge_of = fall ? fall_v[src] : rise_v[src];
    endfunction : edge_of

    // Pattern match: ignored inputs always match
    function automatic logic pat_match(input logic [NCH-1:0] lvl, input logic [NCH-1:0] want,
                                       input logic [NCH-1:0] care);
        pat_match = &(~care | ~(lvl ^ want));
    endfunction : pat_match

    // Clamp into legal span
    function automatic logic [31:0] clamp32(input logic [31:0] v, input logic [31:0] lo,
                                            input logic [31:0] hi);
        if (v < lo) begin
            clamp32 = lo;
        end else if (v > hi) begin
            clamp32 = hi;
        end else begin
            clamp32 = v;
        end
    endfunction : clamp32

    // ------------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------------
    logic [NCH-1:0] lvl;
    logic [NCH-1:0] rise;
    logic [NCH-1:0] fall;

    stq_sync #(
        .W (NCH)
    ) u_sync (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_async   (i_comp),
        .o_level   (lvl),
        .o_rise    (rise),
        .o_fall    (fall)
    );

    // ------------------------------------------------------------------
    // Clamped settings
    // ------------------------------------------------------------------
    logic [31:0]      lim1_w;
    logic [31:0]      lim2_w;
    logic [31:0]      hot_w;
    logic [31:0]      hoe_w;
    logic [31:0]      dly_w;
    logic [LIM_W-1:0] lim1;
    logic [LIM_W-1:0] lim2;
    logic [HO_W-1:0]  ho_cyc;
    logic [CNT_W-1:0] ho_evt;
    logic [CNT_W-1:0] dly_cnt;

    // limits held inside 20 ns to 160 ms
    assign lim1_w = clamp32({6'h00, i_cfg.tq_lim1}, 32'(TQ_MIN_CYC), 32'(LIM_MAX_CYC));
    assign lim2_w = clamp32({6'h00, i_cfg.tq_lim2}, 32'(TQ_MIN_CYC), 32'(LIM_MAX_CYC));
    assign lim1   = lim1_w[LIM_W-1:0];
    assign lim2   = lim2_w[LIM_W-1:0];
    assign hot_w  = clamp32({5'h00, i_cfg.ho_time}, 32'(HO_MIN_CYC), 32'(HOT_MAX_CYC));
    assign hoe_w  = clamp32({8'h00, i_cfg.ho_events}, 32'(EVT_MIN), 32'(EVT_MAX_CNT));
    assign ho_cyc = (i_cfg.mode == MODE_DELAYED) ? HO_W'(DLY_HO_CYC) : hot_w[HO_W-1:0];
    assign ho_evt = hoe_w[CNT_W-1:0];
    // occurrence count from one to sixteen million
    assign dly_w   = clamp32({8'h00, i_cfg.dly_count}, 32'(DLY_MIN), 32'(DLY_MAX_CNT));
    assign dly_cnt = dly_w[CNT_W-1:0];

    // ------------------------------------------------------------------
    // Pattern tracking and duration filter
    // ------------------------------------------------------------------
    logic             pat_now;
    logic             pat_prev_r;
    logic             pat_enter;
    logic             pat_exit;
    logic [LIM_W-1:0] dur_r;
    logic [LIM_W-1:0] dur_nxt;
    logic             tq_ok;

    assign pat_now   = pat_match(lvl, i_cfg.pat_want, i_cfg.pat_care);
    assign pat_enter = pat_now & ~pat_prev_r;
    assign pat_exit  = ~pat_now & pat_prev_r;

    // Previous pattern state for entry and exit edges
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            pat_prev_r <= 1'b0;
        end else begin
            pat_prev_r <= pat_now;
        end
    end

    // restart timing at once on each new entry
    always_comb begin
        dur_nxt = dur_r;
        if (pat_enter) begin
            dur_nxt = LIM_W'(1);
        end else if (pat_now && (dur_r != {LIM_W{1'b1}})) begin
            dur_nxt = dur_r + LIM_W'(1);
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            dur_r <= DUR_RST;
        end else begin
            dur_r <= dur_nxt;
        end
    end

    always_comb begin
        case (i_cfg.tq_sel)
            // shorter mode needs a minimum presence
            TQ_SHORTER: tq_ok = (dur_r < lim1) && (dur_r >= LIM_W'(GLITCH_MIN_CYC));
            TQ_LONGER:  tq_ok = (dur_r > lim1);
            TQ_RANGE:   tq_ok = (dur_r > lim1) && (dur_r < lim2);
            default:    tq_ok = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // Qualifier conditions
    // ------------------------------------------------------------------
    logic           q_edge;
    logic           q_pat;
    logic           q_tq;
    logic           q_state;
    logic [NCH-1:0] st_care;
    logic           cond_now;
    logic           arm_cond;

    // edge on selected source and polarity
    assign q_edge  = edge_of(i_cfg.edge_src, i_cfg.edge_fall, rise, fall);
    assign q_pat   = i_cfg.pat_exit ? pat_exit : pat_enter;
    // glitch capture uses the shorter-than exit
    assign q_tq    = pat_exit & tq_ok;
    // clock input dropped from the pattern
    assign st_care = i_cfg.pat_care & ~(NCH'(1) << i_cfg.st_clk_src);
    assign q_state = edge_of(i_cfg.st_clk_src, i_cfg.st_clk_fall, rise, fall)
                   & (pat_match(lvl, i_cfg.pat_want, st_care) ^ i_cfg.st_on_false);

    // Condition of the plain modes
    always_comb begin
        case (i_cfg.mode)
            MODE_EDGE:    cond_now = q_edge;
            MODE_PATTERN: cond_now = q_pat;
            MODE_TIMEQ:   cond_now = q_tq;
            MODE_STATE:   cond_now = q_state;
            default:      cond_now = 1'b0;
        endcase
    end

    always_comb begin
        case (i_cfg.arm_sel)
            QUAL_EDGE:    arm_cond = q_edge;
            QUAL_PATTERN: arm_cond = q_pat;
            QUAL_TIMEQ:   arm_cond = q_tq;
            QUAL_STATE:   arm_cond = q_state;
            default:      arm_cond = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // Event-delayed sequencer
    // ------------------------------------------------------------------
    stq_dstate_t      dstate_r;
    logic [CNT_W-1:0] dcnt_r;
    logic             dly_edge;
    logic             trg_edge;
    logic             dly_fire;
    logic             ho_busy_r;

    assign dly_edge = edge_of(i_cfg.dly_src, i_cfg.dly_fall, rise, fall);
    assign trg_edge = edge_of(i_cfg.trg_src, i_cfg.trg_fall, rise, fall);
    assign dly_fire = (dstate_r == DS_FIRE) && trg_edge;

    // arm, count delay edges, then wait for the trigger edge
    always_ff @(posedge i_sys_clk) begin
        if (i_rst || (i_cfg.mode != MODE_DELAYED)) begin
            dstate_r <= DS_ARM;
            dcnt_r   <= CNT_RST;
        end else begin
            case (dstate_r)
                DS_ARM: begin
                    if (!ho_busy_r && arm_cond) begin
                        dstate_r <= DS_COUNT;
                        dcnt_r   <= CNT_RST;
                    end
                end
                DS_COUNT: begin
                    // one edge per cycle counted without loss
                    if (dly_edge) begin
                        if (dcnt_r + CNT_W'(1) >= dly_cnt) begin
                            dstate_r <= DS_FIRE;
                        end
                        dcnt_r <= dcnt_r + CNT_W'(1);
                    end
                end
                DS_FIRE: begin
                    if (trg_edge) begin
                        dstate_r <= DS_ARM;
                    end
                end
                default: begin
                    dstate_r <= DS_ARM;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Holdoff and trigger
    // ------------------------------------------------------------------
    logic             cand;
    logic             fire;
    logic [HO_W-1:0]  ho_tcnt_r;
    logic [CNT_W-1:0] ho_ecnt_r;
    logic             ev_mode;

    assign cand    = (i_cfg.mode == MODE_DELAYED) ? dly_fire : cond_now;
    assign fire    = cand && !ho_busy_r;
    assign ev_mode = i_cfg.ho_by_events && (i_cfg.mode != MODE_DELAYED);

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            ho_busy_r <= 1'b0;
            ho_tcnt_r <= HO_RST;
            ho_ecnt_r <= CNT_RST;
        end else if (fire) begin
            ho_busy_r <= 1'b1;
            ho_tcnt_r <= ho_cyc - HO_W'(1);
            ho_ecnt_r <= ho_evt - CNT_W'(1);
        end else if (ho_busy_r) begin
            if (ev_mode) begin
                if (cand) begin
                    ho_ecnt_r <= ho_ecnt_r - CNT_W'(1);
                    ho_busy_r <= (ho_ecnt_r > CNT_W'(1));
                end
            end else begin
                ho_tcnt_r <= ho_tcnt_r - HO_W'(1);
                ho_busy_r <= (ho_tcnt_r > HO_W'(1));
            end
        end
    end

    // Free running timestamp
    logic [TS_W-1:0] ts_r;

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            ts_r <= TS_RST;
        end else begin
            ts_r <= ts_r + TS_W'(1);
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_trig <= 1'b0;
        end else begin
            o_trig <= fire;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_trig_time <= TS_RST;
            o_ref_time  <= TS_RST;
            o_ref_idx   <= '0;
        end else if (fire) begin
            o_trig_time <= ts_r;
            o_ref_time  <= ts_r + TS_W'(signed'(i_cfg.ref_delay));
            case (i_cfg.ref_loc)
                REF_LEFT:   o_ref_idx <= '0;
                REF_CENTRE: o_ref_idx <= IDX_W'(REC_LEN / 2);
                REF_RIGHT:  o_ref_idx <= IDX_W'(REC_LEN - 1);
                default:    o_ref_idx <= '0;
            endcase
        end
    end

    // Status outputs
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_holdoff   <= 1'b0;
            o_dly_state <= DS_ARM;
            o_pat_true  <= 1'b0;
        end else begin
            o_holdoff   <= ho_busy_r;
            o_dly_state <= dstate_r;
            o_pat_true  <= pat_now;
        end
    end

endmodule : stq_top

/* File: sim/stq_properties.sv */
// Port checker for the trigger qualifier, bound into stq_top.
// Assumes settings stay steady around each trigger.
`timescale 1ns/10ps
module stq_properties
    import stq_pkg::*;
#(
    parameter int REC_LEN = REC_LEN_DEF
) (
    input wire logic             i_sys_clk,
    input wire logic             i_rst,
    input wire logic [NCH-1:0]   i_comp,
    input wire stq_cfg_t         i_cfg,
    input wire logic             o_trig,
    input wire logic [TS_W-1:0]  o_trig_time,
    input wire logic [TS_W-1:0]  o_ref_time,
    input wire logic [IDX_W-1:0] o_ref_idx,
    input wire logic             o_holdoff,
    input wire logic [1:0]       o_dly_state,
    input wire logic             o_pat_true
);
    // ----
    // Properties
    // ----
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    property p_pulse; o_trig |=> !o_trig; endproperty
    a_pulse: assert property (p_pulse) else $error("trigger pulse too long");
    property p_hold; o_trig && !i_cfg.ho_by_events |=> o_holdoff [*8]; endproperty
    a_hold: assert property (p_hold) else $error("holdoff too short");
    property p_block; o_holdoff && !i_cfg.ho_by_events |-> !o_trig; endproperty
    a_block: assert property (p_block) else $error("trigger during holdoff");
    property p_idx;
        o_trig |-> o_ref_idx == ((i_cfg.ref_loc == REF_CENTRE) ? IDX_W'(REC_LEN / 2) :
                                 (i_cfg.ref_loc == REF_RIGHT) ? IDX_W'(REC_LEN - 1) : '0);
    endproperty
    a_idx: assert property (p_idx) else $error("reference index wrong");
    property p_ref; o_trig |-> o_ref_time == o_trig_time + {{8{i_cfg.ref_delay[31]}}, i_cfg.ref_delay}; endproperty
    a_ref: assert property (p_ref) else $error("reference time wrong");
    property p_edge;
        i_cfg.mode == MODE_EDGE && !i_cfg.edge_fall && !i_cfg.ho_by_events && !o_holdoff && !o_trig
            && $rose(i_comp[i_cfg.edge_src]) |-> ##[1:5] o_trig;
    endproperty
    a_edge: assert property (p_edge) else $error("edge missed");
    property p_pat;
        (i_cfg.mode == MODE_PATTERN && $stable(i_comp) && $stable(i_cfg)) [*5]
            |-> o_pat_true == ((i_comp & i_cfg.pat_care) == (i_cfg.pat_want & i_cfg.pat_care));
    endproperty
    a_pat: assert property (p_pat) else $error("pattern flag wrong");
    property p_dly; (i_cfg.mode != MODE_DELAYED) [*3] |-> o_dly_state == DS_ARM; endproperty
    a_dly: assert property (p_dly) else $error("sequencer not idle");
    c_pat: cover property (o_trig && i_cfg.mode == MODE_PATTERN);
    c_tq: cover property (o_trig && i_cfg.mode == MODE_TIMEQ);
    c_dly: cover property (o_trig && i_cfg.mode == MODE_DELAYED);
endmodule : stq_properties
bind stq_top stq_properties #(.REC_LEN(REC_LEN)) u_stq_properties (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_comp(i_comp), .i_cfg(i_cfg), .o_trig(o_trig),
    .o_trig_time(o_trig_time), .o_ref_time(o_ref_time), .o_ref_idx(o_ref_idx),
    .o_holdoff(o_holdoff), .o_dly_state(o_dly_state), .o_pat_true(o_pat_true));

/* File: sim/stq_comp_model.sv */
// Model of the four level comparators in front of the qualifier.
// Assumes bench-driven levels; decisions lag one cycle.
`timescale 1ns/10ps
module stq_comp_model
    import stq_pkg::*;
(
    input  wire logic           i_sys_clk,
    input  wire logic [NCH-1:0] i_lvl,
    output logic      [NCH-1:0] o_comp
);
    // Comparator decision, low at start
    initial o_comp = '0;
    always @(posedge i_sys_clk) begin
        o_comp <= i_lvl;
    end
endmodule : stq_comp_model

/* File: sim/tb_top.sv */
// Self-checking bench for the trigger qualifier, one task per scenario.
// Assumes shortened count parameters.
`timescale 1ns/10ps
module tb_top
    import stq_pkg::*;
;
    logic             i_sys_clk = 1'b0;
    logic             i_rst     = 1'b1;
    logic [NCH-1:0]   lvl       = 4'h0;
    logic [NCH-1:0]   i_comp;
    stq_cfg_t         cfg       = '0;
    stq_cfg_t         cn;
    logic             o_trig, o_holdoff, o_pat_true;
    logic [TS_W-1:0]  o_trig_time, o_ref_time;
    logic [IDX_W-1:0] o_ref_idx;
    logic [1:0]       o_dly_state;
    int               fail_count = 0;
    int               checks_done = 0;
    int               ntrig = 0;
    int               n0;
    stq_comp_model u_stq_comp_model (.i_sys_clk(i_sys_clk), .i_lvl(lvl), .o_comp(i_comp));
    stq_top #(.LIM_MAX_CYC(64), .HOT_MAX_CYC(64), .EVT_MAX_CNT(8), .DLY_MAX_CNT(8)) u_stq_top (
        .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_comp(i_comp), .i_cfg(cfg), .o_trig(o_trig),
        .o_trig_time(o_trig_time), .o_ref_time(o_ref_time), .o_ref_idx(o_ref_idx),
        .o_holdoff(o_holdoff), .o_dly_state(o_dly_state), .o_pat_true(o_pat_true));
    // ----
    // Clock, trigger count and helpers
    // ----
    initial forever #2 i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk) if (o_trig === 1'b1) ntrig <= ntrig + 1;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Drive levels for n cycles
    task automatic step(input logic [3:0] v, input int n);
        @(posedge i_sys_clk);
        lvl <= v;
        repeat (n - 1) @(posedge i_sys_clk);
        #1;
    endtask : step
    task automatic apply;
        @(posedge i_sys_clk);
        cfg <= cn;
    endtask : apply
    task automatic setup(input stq_mode_t m);
        cn = '0;
        cn.mode = m;
        cn.ho_time = 27'h000_000A;
    endtask : setup
    task automatic t_edge;
        logic [3:0] m;
        for (int i = 0; i < 8; i++) begin
            m = 4'h1 << i[1:0];
            setup(MODE_EDGE);
            cn.edge_src = i[1:0];
            cn.edge_fall = i[2];
            cn.ref_loc = stq_ref_t'(i % 3);
            cn.ref_delay = 32'hFFFF_FFFB;
            apply();
            step({4{i[2]}}, 16);
            n0 = ntrig;
            step(lvl ^ ~m, 4);
            step(lvl ^ ~m, 16);
            chk(16'(ntrig - n0), 16'h0000);
            step(lvl ^ m, 16);
            chk(16'(ntrig - n0), 16'h0001);
            chk(16'(o_ref_idx), (i % 3 == 0) ? 16'h0000 : (i % 3 == 1) ? 16'h0200 : 16'h03FF);
            step(lvl ^ m, 16);
            chk(16'(ntrig - n0), 16'h0001);
        end
    endtask : t_edge
    task automatic t_pattern;
        setup(MODE_PATTERN);
        cn.pat_want = 4'h6;
        cn.pat_care = 4'hE;
        apply();
        step(4'h0, 16);
        n0 = ntrig;
        step(4'h7, 16);
        chk(16'(o_pat_true), 16'h0001);
        step(4'h0, 16);
        chk(16'(ntrig - n0), 16'h0001);
        cn.pat_exit = 1'b1;
        apply();
        step(4'h6, 16);
        step(4'h2, 16);
        chk(16'(ntrig - n0), 16'h0002);
    endtask : t_pattern
    task automatic t_timeq;
        int sel[7] = '{0, 0, 0, 1, 1, 2, 2};
        int dur[7] = '{1, 4, 12, 12, 4, 7, 12};
        int hit[7] = '{1, 1, 0, 1, 0, 1, 0};
        for (int i = 0; i < 7; i++) begin
            setup(MODE_TIMEQ);
            cn.pat_want = 4'h1;
            cn.pat_care = 4'h1;
            cn.tq_sel = stq_tq_t'(sel[i]);
            cn.tq_lim1 = (sel[i] == 2) ? 26'h000_0005 : 26'h000_0008;
            cn.tq_lim2 = 26'h000_000A;
            apply();
            step(4'h0, 16);
            n0 = ntrig;
            step(4'h1, dur[i]);
            step(4'h0, 20);
            chk(16'(ntrig - n0), 16'(hit[i]));
        end
        cn.tq_sel = TQ_SHORTER;
        cn.tq_lim1 = 26'h000_0008;
        apply();
        n0 = ntrig;
        step(4'h1, 12);
        step(4'h0, 3);
        step(4'h1, 4);
        step(4'h0, 20);
        chk(16'(ntrig - n0), 16'h0001);
    endtask : t_timeq
    task automatic t_state;
        setup(MODE_STATE);
        cn.st_clk_src = 2'h3;
        cn.pat_want = 4'h5;
        cn.pat_care = 4'hF;
        for (int i = 0; i < 4; i++) begin
            cn.st_on_false = i[0];
            apply();
            step(i[1] ? 4'h1 : 4'h5, 16);
            n0 = ntrig;
            step(lvl ^ 4'h8, 4);
            step(lvl ^ 4'h8, 16);
            chk(16'(ntrig - n0), 16'(i[0] == i[1]));
        end
    endtask : t_state
    task automatic t_delayed;
        for (int j = 0; j < 4; j++) begin
            setup(MODE_DELAYED);
            cn.arm_sel = stq_qual_t'(j);
            cn.pat_want = 4'h1;
            cn.pat_care = 4'h1;
            cn.tq_lim1 = 26'h000_0008;
            cn.dly_src = 2'h1;
            cn.dly_count = 24'h00_0003;
            cn.trg_src = 2'h2;
            apply();
            step(4'h0, 16);
            n0 = ntrig;
            step(4'h1, 4);
            step(4'h0, 8);
            chk(16'(o_dly_state), 16'h0001);
            repeat (2) begin
                step(4'h2, 2);
                step(4'h0, 2);
            end
            step(4'h4, 4);
            step(4'h0, 8);
            chk(16'(ntrig - n0), 16'h0000);
            step(4'h2, 2);
            step(4'h0, 8);
            chk(16'(o_dly_state), 16'h0002);
            step(4'h4, 4);
            step(4'h0, 16);
            chk(16'(ntrig - n0), 16'h0001);
        end
    endtask : t_delayed
    task automatic t_hold;
        int want[4] = '{1, 1, 1, 2};
        setup(MODE_EDGE);
        cn.ho_by_events = 1'b1;
        cn.ho_events = 24'h00_0003;
        apply();
        step(4'h0, 16);
        n0 = ntrig;
        for (int i = 0; i < 4; i++) begin
            step(4'h1, 4);
            step(4'h0, 16);
            chk(16'(ntrig - n0), 16'(want[i]));
        end
        cn.ho_by_events = 1'b0;
        cn.ho_time = 27'h000_0014;
        apply();
        step(4'h0, 16);
        n0 = ntrig;
        step(4'h1, 3);
        step(4'h0, 3);
        step(4'h1, 3);
        step(4'h0, 30);
        chk(16'(ntrig - n0), 16'h0001);
    endtask : t_hold
    // ----
    // Sequence, watchdog and verdict
    // ----
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test
    initial begin
        repeat (3) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        step(4'h0, 4);
        t_edge();
        t_pattern();
        t_timeq();
        t_state();
        t_delayed();
        t_hold();
        finish_test();
    end
    // About six times the expected 1,609 cycles
    initial begin
        #40000;
        fail_count++;
        finish_test();
    end
endmodule : tb_top
